// ### core/fpd_process_map.sv
`timescale 1ns/1ps
`default_nettype none
module fpd_process_map #(
   parameter int HALF_CHAR_CYCLES = fpd_pkg::HALF_CHAR_CYCLES,
   parameter int DIN_W = 8
) (
   input wire logic I_CLK_SYS,
   input wire logic I_NRST,
   // register bus
   input wire logic [7:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   input wire logic [7:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY,
   // drive state
   input wire fpd_pkg::fpd_drive_status_s I_STATUS,
   input wire logic [DIN_W-1:0] I_DIN,
   input wire fpd_pkg::fpd_prog_write_s I_PROG,
   // cyclic process words
   input wire logic I_PDI_VALID,
   input wire logic [15:0] I_PDI3,
   input wire logic [15:0] I_PDI4,
   output logic [15:0] O_PDO3,
   output logic [15:0] O_USER_REF,
   output logic O_USER_REF_STB,
   output logic [15:0] O_RAMP_TIME,
   output logic O_RAMP_TIME_STB,
   output logic [15:0] O_USER_REG3,
   output logic [15:0] O_USER_REG4,
   // serial request side
   input wire logic I_REQ_DONE,
   input wire logic [7:0] I_REQ_ADDR,
   output logic O_REPLY_GO,
   output logic [7:0] O_NODE_ADDR
);
   if (DIN_W < 1 || DIN_W > 16)
   begin : g_bad
      $error("fpd_process_map: DIN_W must be 1 to 16");
   end

   // write channel
   logic wr_fire;
   logic wr_hit;

   // sub-word writes merge into the current value before the range check;
   // every operand is an argument so port connections track all of them
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
      return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge

   // accept address and data together, one write in flight at most
   assign wr_fire = I_AWVALID && I_WVALID && !O_AWREADY && !O_BVALID;

   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_NRST)
      begin
         O_AWREADY <= 1'b0;
         O_WREADY <= 1'b0;
      end
      else
      begin
         O_AWREADY <= wr_fire;
         O_WREADY <= wr_fire;
      end
   end

   // write lands on the edge where the readies are high
   logic wr_take;
   logic [7:0] wr_addr_q;
   logic [31:0] wr_data_q;
   logic [3:0] wr_strb_q;
   assign wr_take = O_AWREADY;

   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_NRST)
      begin
         wr_addr_q <= 8'h00;
         wr_data_q <= 32'h0000_0000;
         wr_strb_q <= 4'h0;
      end
      else if (wr_fire)
      begin
         wr_addr_q <= I_AWADDR;
         wr_data_q <= I_WDATA;
         wr_strb_q <= I_WSTRB;
      end
   end

   always_comb
   begin
      unique case (wr_addr_q)
         fpd_pkg::ADDR_OUT3_SRC, fpd_pkg::ADDR_IN4_FUNC,
         fpd_pkg::ADDR_IN3_FUNC, fpd_pkg::ADDR_REPLY_DLY,
         fpd_pkg::ADDR_EXT_NODE, fpd_pkg::ADDR_BASIC_NODE,
         fpd_pkg::ADDR_USER1, fpd_pkg::ADDR_USER2,
         fpd_pkg::ADDR_USER3, fpd_pkg::ADDR_USER4:
            wr_hit = 1'b1;
         default:
            wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_NRST)
      begin
         O_BVALID <= 1'b0;
         O_BRESP <= fpd_pkg::RESP_OKAY;
      end
      else if (wr_take)
      begin
         O_BVALID <= 1'b1;
         O_BRESP <= wr_hit ? fpd_pkg::RESP_OKAY : fpd_pkg::RESP_SLVERR;
      end
      else if (I_BREADY)
         O_BVALID <= 1'b0;
   end

   // configuration registers
   logic [15:0] out3_src, in4_func, in3_func;
   logic [15:0] reply_extra_delay, extended_node_address;
   logic [15:0] basic_node_address, user_reg1, user_reg2;

   fpd_sel_reg #(.W(16), .MAX(fpd_pkg::OUT3_SRC_MAX),
                 .RST(fpd_pkg::OUT3_SRC_RST)) u_out3_src ( // [RQ1]
      .i_clk(I_CLK_SYS), .i_nrst(I_NRST), .o_value(out3_src),
      .i_wr(wr_take && wr_addr_q == fpd_pkg::ADDR_OUT3_SRC),
      .i_data(merge(out3_src, wr_data_q, wr_strb_q)));
   fpd_sel_reg #(.W(16), .MAX(fpd_pkg::IN4_FUNC_MAX),
                 .RST(fpd_pkg::IN4_FUNC_RST)) u_in4_func ( // [RQ9]
      .i_clk(I_CLK_SYS), .i_nrst(I_NRST), .o_value(in4_func),
      .i_wr(wr_take && wr_addr_q == fpd_pkg::ADDR_IN4_FUNC),
      .i_data(merge(in4_func, wr_data_q, wr_strb_q)));
   fpd_sel_reg #(.W(16), .MAX(fpd_pkg::IN3_FUNC_MAX),
                 .RST(fpd_pkg::IN3_FUNC_RST)) u_in3_func ( // [RQ10]
      .i_clk(I_CLK_SYS), .i_nrst(I_NRST), .o_value(in3_func),
      .i_wr(wr_take && wr_addr_q == fpd_pkg::ADDR_IN3_FUNC),
      .i_data(merge(in3_func, wr_data_q, wr_strb_q)));
   fpd_sel_reg #(.W(16), .MAX(fpd_pkg::REPLY_DLY_MAX),
                 .RST(fpd_pkg::REPLY_DLY_RST)) u_reply_dly ( // [RQ13]
      .i_clk(I_CLK_SYS), .i_nrst(I_NRST), .o_value(reply_extra_delay),
      .i_wr(wr_take && wr_addr_q == fpd_pkg::ADDR_REPLY_DLY),
      .i_data(merge(reply_extra_delay, wr_data_q, wr_strb_q)));
   fpd_sel_reg #(.W(16), .MAX(fpd_pkg::EXT_NODE_MAX),
                 .RST(fpd_pkg::EXT_NODE_RST)) u_ext_node ( // [RQ14]
      .i_clk(I_CLK_SYS), .i_nrst(I_NRST), .o_value(extended_node_address),
      .i_wr(wr_take && wr_addr_q == fpd_pkg::ADDR_EXT_NODE),
      .i_data(merge(extended_node_address, wr_data_q, wr_strb_q)));
   fpd_sel_reg #(.W(16), .MAX(fpd_pkg::BASIC_NODE_MAX),
                 .RST(fpd_pkg::BASIC_NODE_RST)) u_basic_node ( // [RQ15]
      .i_clk(I_CLK_SYS), .i_nrst(I_NRST), .o_value(basic_node_address),
      .i_wr(wr_take && wr_addr_q == fpd_pkg::ADDR_BASIC_NODE),
      .i_data(merge(basic_node_address, wr_data_q, wr_strb_q)));

   // program logic wins over a bus write landing in the same cycle
   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_NRST)
      begin
         user_reg1 <= 16'h0000;
         user_reg2 <= 16'h0000;
      end
      else
      begin
         if (I_PROG.wr && !I_PROG.sel) // [RQ7]
            user_reg1 <= I_PROG.data;
         else if (wr_take && wr_addr_q == fpd_pkg::ADDR_USER1)
            user_reg1 <= merge(user_reg1, wr_data_q, wr_strb_q);
         if (I_PROG.wr && I_PROG.sel) // [RQ7]
            user_reg2 <= I_PROG.data;
         else if (wr_take && wr_addr_q == fpd_pkg::ADDR_USER2)
            user_reg2 <= merge(user_reg2, wr_data_q, wr_strb_q);
      end
   end

   // inbound process words; the network word wins over a bus write
   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_NRST)
      begin
         O_USER_REF <= 16'h0000;
         O_USER_REF_STB <= 1'b0;
         O_RAMP_TIME <= 16'h0000;
         O_RAMP_TIME_STB <= 1'b0;
         O_USER_REG3 <= 16'h0000;
         O_USER_REG4 <= 16'h0000;
      end
      else
      begin
         O_USER_REF_STB <= 1'b0;
         O_RAMP_TIME_STB <= 1'b0;
         if (I_PDI_VALID && in3_func == 16'h0001)
         begin
            // above full scale is held at 100.0 %
            O_USER_REF <= (I_PDI3 > fpd_pkg::USER_REF_MAX) ?
                          fpd_pkg::USER_REF_MAX : I_PDI3; // [RQ11]
            O_USER_REF_STB <= 1'b1;
         end
         if (I_PDI_VALID && in3_func == 16'h0002)
            O_USER_REG3 <= I_PDI3; // [RQ11]
         else if (wr_take && wr_addr_q == fpd_pkg::ADDR_USER3)
            O_USER_REG3 <= merge(O_USER_REG3, wr_data_q, wr_strb_q);
         // code 0 of word three leaves everything untouched [RQ10]
         if (I_PDI_VALID && in4_func == 16'h0000)
         begin
            O_RAMP_TIME <= I_PDI4; // [RQ9]
            O_RAMP_TIME_STB <= 1'b1;
         end
         if (I_PDI_VALID && in4_func == 16'h0001)
            O_USER_REG4 <= I_PDI4; // [RQ9]
         else if (wr_take && wr_addr_q == fpd_pkg::ADDR_USER4)
            O_USER_REG4 <= merge(O_USER_REG4, wr_data_q, wr_strb_q);
      end
   end

   // digital inputs come from pins
   logic [DIN_W-1:0] din_meta;
   logic [DIN_W-1:0] din_sync;

   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_NRST)
      begin
         din_meta <= '0;
         din_sync <= '0;
      end
      else
      begin
         din_meta <= I_DIN;
         din_sync <= din_meta;
      end
   end

   // outbound word three
   logic [15:0] next_pdo3;
   fpd_pkg::fpd_out3_e out3_code;
   assign out3_code = fpd_pkg::fpd_out3_e'(out3_src[2:0]);

   always_comb
   begin
      unique case (out3_code)
         fpd_pkg::OUT3_CURRENT:
            next_pdo3 = I_STATUS.motor_current; // [RQ2]
         fpd_pkg::OUT3_POWER:
            next_pdo3 = I_STATUS.output_power; // [RQ3]
         fpd_pkg::OUT3_DIGITAL:
            next_pdo3 = 16'(din_sync); // [RQ4]
         fpd_pkg::OUT3_ANALOG2:
            next_pdo3 = I_STATUS.analog2_level; // [RQ5]
         fpd_pkg::OUT3_HEATSINK:
            next_pdo3 = I_STATUS.heatsink_temp; // [RQ6]
         fpd_pkg::OUT3_USER1:
            next_pdo3 = user_reg1; // [RQ7]
         fpd_pkg::OUT3_USER2:
            next_pdo3 = user_reg2; // [RQ7]
         fpd_pkg::OUT3_MONITOR:
            next_pdo3 = I_STATUS.monitor_display_value; // [RQ8]
      endcase
   end

   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_NRST)
         O_PDO3 <= 16'h0000;
      else
         O_PDO3 <= next_pdo3;
   end

   // effective node address
   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_NRST)
         O_NODE_ADDR <= 8'(fpd_pkg::BASIC_NODE_RST);
      else if (extended_node_address != 16'h0000)
         O_NODE_ADDR <= extended_node_address[7:0]; // [RQ14]
      else
         O_NODE_ADDR <= basic_node_address[7:0]; // [RQ15]
   end

   // reply timing
   logic req_for_us;
   logic timer_go;
   assign req_for_us = I_REQ_DONE && I_REQ_ADDR == O_NODE_ADDR; // [RQ16]

   fpd_reply_timer #(.HALF_CYCLES(HALF_CHAR_CYCLES)) u_reply_timer (
      .i_clk(I_CLK_SYS),
      .i_nrst(I_NRST),
      .i_start(req_for_us),
      .i_extra(reply_extra_delay[4:0]), // [RQ12]
      .o_go(timer_go),
      .o_busy()
   );

   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_NRST)
         O_REPLY_GO <= 1'b0;
      else
         O_REPLY_GO <= timer_go;
   end

   // read channel
   logic [31:0] rd_data;
   logic rd_hit;

   always_comb
   begin
      rd_hit = 1'b1;
      rd_data = 32'h0000_0000;
      unique case (I_ARADDR)
         fpd_pkg::ADDR_OUT3_SRC: rd_data[15:0] = out3_src;
         fpd_pkg::ADDR_IN4_FUNC: rd_data[15:0] = in4_func;
         fpd_pkg::ADDR_IN3_FUNC: rd_data[15:0] = in3_func;
         fpd_pkg::ADDR_REPLY_DLY: rd_data[15:0] = reply_extra_delay;
         fpd_pkg::ADDR_EXT_NODE: rd_data[15:0] = extended_node_address;
         fpd_pkg::ADDR_BASIC_NODE: rd_data[15:0] = basic_node_address;
         fpd_pkg::ADDR_USER1: rd_data[15:0] = user_reg1;
         fpd_pkg::ADDR_USER2: rd_data[15:0] = user_reg2;
         fpd_pkg::ADDR_USER3: rd_data[15:0] = O_USER_REG3;
         fpd_pkg::ADDR_USER4: rd_data[15:0] = O_USER_REG4;
         fpd_pkg::ADDR_EFF_NODE: rd_data[7:0] = O_NODE_ADDR;
         fpd_pkg::ADDR_OUT3_VALUE: rd_data[15:0] = O_PDO3;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_NRST)
      begin
         O_ARREADY <= 1'b0;
         O_RVALID <= 1'b0;
         O_RDATA <= 32'h0000_0000;
         O_RRESP <= fpd_pkg::RESP_OKAY;
      end
      else
      begin
         O_ARREADY <= I_ARVALID && !O_ARREADY && !O_RVALID;
         if (I_ARVALID && !O_ARREADY && !O_RVALID)
         begin
            O_RVALID <= 1'b1;
            O_RDATA <= rd_data;
            O_RRESP <= rd_hit ? fpd_pkg::RESP_OKAY : fpd_pkg::RESP_SLVERR;
         end
         else if (O_RVALID && I_RREADY)
            O_RVALID <= 1'b0;
      end
   end
endmodule : fpd_process_map
`default_nettype wire

// ### shared/fpd_pkg.sv
// Notes on behaviour
// [RQ1] The outbound word-three source selector accepts codes 0 to 7 and resets to 0.
// [RQ2] Code 0 sends motor current carrying one implied decimal digit.
// [RQ3] Code 1 sends output power in kW carrying two implied decimal digits.
// [RQ4] Code 2 sends the digital input bitmap, with bit 0 for input one and upward.
// [RQ5] Code 3 sends the second analog input, where 0 to 1000 spans 0 to 100.0 %.
// [RQ6] Code 4 sends heatsink temperature, where 0 to 100 means 0 to 100 degC.
// [RQ7] Codes 5 and 6 send user registers one and two, which program logic may also write.
// [RQ8] Code 7 sends the monitor display value, whose source is picked elsewhere.
// [RQ9] The inbound word-four selector takes 0 or 1 (reset 0): 0 gives ramp time, 1 loads user register four.
// [RQ10] The inbound word-three selector takes 0 to 2 (reset 0), and code 0 drops the word.
// [RQ11] Inbound word-three code 1 gives a user reference of 0 to 1000, and code 2 loads user register three.
// [RQ12] A reply waits the protocol minimum gap plus 0 to 16 extra character times.
// [RQ13] The extra reply delay resets to zero characters.
// [RQ14] The extended node address takes 0 to 247, and any nonzero value is the effective address.
// [RQ15] When the extended address is zero, the basic address (at most 63) is the effective address.
// [RQ16] Only frames sent to the effective address are answered, and all others are ignored.
// [RQ17] A selector write that is out of range is rejected, and the old code stays.
package fpd_pkg;
   localparam logic [7:0] ADDR_OUT3_SRC = 8'h00;
   localparam logic [7:0] ADDR_IN4_FUNC = 8'h04;
   localparam logic [7:0] ADDR_IN3_FUNC = 8'h08;
   localparam logic [7:0] ADDR_REPLY_DLY = 8'h0C;
   localparam logic [7:0] ADDR_EXT_NODE = 8'h10;
   localparam logic [7:0] ADDR_BASIC_NODE = 8'h14;
   localparam logic [7:0] ADDR_USER1 = 8'h18;
   localparam logic [7:0] ADDR_USER2 = 8'h1C;
   localparam logic [7:0] ADDR_USER3 = 8'h20;
   localparam logic [7:0] ADDR_USER4 = 8'h24;
   localparam logic [7:0] ADDR_EFF_NODE = 8'h28;
   localparam logic [7:0] ADDR_OUT3_VALUE = 8'h2C;

   localparam int OUT3_SRC_MAX = 7;
   localparam int IN4_FUNC_MAX = 1;
   localparam int IN3_FUNC_MAX = 2;
   localparam int REPLY_DLY_MAX = 16;
   localparam int EXT_NODE_MAX = 247;
   localparam int BASIC_NODE_MAX = 63;
   localparam int OUT3_SRC_RST = 0;
   localparam int IN4_FUNC_RST = 0;
   localparam int IN3_FUNC_RST = 0;
   localparam int REPLY_DLY_RST = 0;
   localparam int EXT_NODE_RST = 0;
   localparam int BASIC_NODE_RST = 1;
   localparam logic [15:0] USER_REF_MAX = 16'h03E8;

   localparam int CLK_HZ = 20_000_000;
   localparam int BAUD_DEFAULT = 19200;
   localparam int CHAR_BITS = 11;
   // a minimum time: round the half-character count up
   localparam int HALF_CHAR_CYCLES =
      (CLK_HZ / 100 * CHAR_BITS + (2 * BAUD_DEFAULT / 100) - 1) /
      (2 * BAUD_DEFAULT / 100);
   // protocol minimum gap of 3.5 characters, in half characters
   localparam int MIN_GAP_HALVES = 7;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      OUT3_CURRENT = 3'h0,
      OUT3_POWER = 3'h1,
      OUT3_DIGITAL = 3'h2,
      OUT3_ANALOG2 = 3'h3,
      OUT3_HEATSINK = 3'h4,
      OUT3_USER1 = 3'h5,
      OUT3_USER2 = 3'h6,
      OUT3_MONITOR = 3'h7
   } fpd_out3_e;

   typedef struct packed {
      logic [15:0] motor_current;
      logic [15:0] output_power;
      logic [15:0] analog2_level;
      logic [15:0] heatsink_temp;
      logic [15:0] monitor_display_value;
   } fpd_drive_status_s;

   typedef struct packed {
      logic wr;
      logic sel;
      logic [15:0] data;
   } fpd_prog_write_s;
endpackage : fpd_pkg

// ### core/fpd_sel_reg.sv
`timescale 1ns/1ps
`default_nettype none
module fpd_sel_reg #(
   parameter int W = 16,
   parameter int MAX = 7,
   parameter int RST = 0
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_wr,
   input wire logic [W-1:0] i_data,
   output logic [W-1:0] o_value
);
   localparam logic [W-1:0] MAX_V = W'(MAX);
   localparam logic [W-1:0] RST_V = W'(RST);

   if (RST > MAX || MAX >= (1 << W))
   begin : g_bad
      $error("fpd_sel_reg: reset above range or range wider than W");
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
         o_value <= RST_V;
      else if (i_wr && i_data <= MAX_V) // [RQ17]
         o_value <= i_data;
   end
endmodule : fpd_sel_reg
`default_nettype wire

// ### core/fpd_reply_timer.sv
`timescale 1ns/1ps
`default_nettype none
module fpd_reply_timer #(
   parameter int HALF_CYCLES = fpd_pkg::HALF_CHAR_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_start,
   input wire logic [4:0] i_extra,
   output logic o_go,
   output logic o_busy
);
   localparam int CW = $clog2(HALF_CYCLES + 1);
   localparam logic [CW-1:0] RELOAD = CW'(HALF_CYCLES - 1);
   localparam logic [5:0] MIN_HALVES = 6'(fpd_pkg::MIN_GAP_HALVES);

   if (HALF_CYCLES < 1)
   begin : g_bad
      $error("fpd_reply_timer: HALF_CYCLES must be at least 1");
   end

   logic [CW-1:0] cyc;
   logic [5:0] halves;

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         o_busy <= 1'b0;
         o_go <= 1'b0;
         cyc <= '0;
         halves <= '0;
      end
      else if (i_start)
      begin
         // a new request restarts the gap: only the latest one is answered
         o_busy <= 1'b1;
         o_go <= 1'b0;
         cyc <= RELOAD;
         halves <= MIN_HALVES + {i_extra, 1'b0}; // [RQ12]
      end
      else if (o_busy)
      begin
         o_go <= 1'b0;
         if (cyc != '0)
            cyc <= cyc - 1'b1;
         else if (halves == 6'h01)
         begin
            o_busy <= 1'b0;
            o_go <= 1'b1;
         end
         else
         begin
            halves <= halves - 1'b1;
            cyc <= RELOAD;
         end
      end
      else
         o_go <= 1'b0;
   end
endmodule : fpd_reply_timer
`default_nettype wire

// ### test/fpd_process_map_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fpd_process_map_sva (
   input wire logic I_CLK_SYS,
   input wire logic I_NRST,
   input wire logic I_ARVALID,
   input wire logic I_BREADY,
   input wire logic O_AWREADY,
   input wire logic O_WREADY,
   input wire logic O_BVALID,
   input wire logic [1:0] O_BRESP,
   input wire logic O_ARREADY,
   input wire logic O_RVALID,
   input wire logic [31:0] O_RDATA,
   input wire logic [15:0] O_USER_REF,
   input wire logic O_REPLY_GO,
   input wire logic [7:0] O_NODE_ADDR
);
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_NRST);
   sequence s_wr_take;
      O_AWREADY && O_WREADY;
   endsequence
   sequence s_rd_take;
      I_ARVALID && !O_ARREADY && !O_RVALID;
   endsequence
   a_wr_pulse: assert property (s_wr_take |=> !O_AWREADY && !O_WREADY)
      else $error("write ready held too long");
   a_aw_pair: assert property (O_AWREADY |-> O_WREADY)
      else $error("write readies apart");
   a_b_after: assert property (s_wr_take |=> O_BVALID)
      else $error("no write response");
   a_b_hold: assert property (O_BVALID && !I_BREADY |=>
      O_BVALID && $stable(O_BRESP))
      else $error("write response dropped early");
   a_b_drop: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
      else $error("write response held after taken");
   a_rd_answer: assert property (s_rd_take |=> O_ARREADY && O_RVALID)
      else $error("read not answered");
   a_r_upper: assert property (O_RVALID |-> O_RDATA[31:16] == 16'h0000)
      else $error("read upper half not zero");
   a_ref_clamp: assert property (O_USER_REF <= 16'h03E8)
      else $error("user reference above full scale");
   a_go_pulse: assert property (O_REPLY_GO |=> !O_REPLY_GO)
      else $error("reply go longer than one cycle");
   a_node_range: assert property (O_NODE_ADDR <= 8'hF7)
      else $error("node address out of range");
endmodule : fpd_process_map_sva
bind fpd_process_map fpd_process_map_sva u_sva (.*);
`default_nettype wire

// ### test/fpd_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpd_master_model (
   input wire logic i_clk,
   output logic o_pdi_valid,
   output logic [15:0] o_pdi3,
   output logic [15:0] o_pdi4,
   output logic o_req_done,
   output logic [7:0] o_req_addr
);
   initial
   begin
      o_pdi_valid = 1'b0;
      o_pdi3 = 16'h5A5A;
      o_pdi4 = 16'hA5A5;
      o_req_done = 1'b0;
      o_req_addr = 8'hFF;
   end
   // lines mean nothing off the strobe, so scramble them there
   task automatic send(input logic [15:0] w3, input logic [15:0] w4);
      @(posedge i_clk);
      o_pdi_valid <= 1'b1;
      o_pdi3 <= w3;
      o_pdi4 <= w4;
      @(posedge i_clk);
      o_pdi_valid <= 1'b0;
      o_pdi3 <= ~w3;
      o_pdi4 <= ~w4;
   endtask : send
   task automatic request(input logic [7:0] a);
      @(posedge i_clk);
      o_req_done <= 1'b1;
      o_req_addr <= a;
      @(posedge i_clk);
      o_req_done <= 1'b0;
      o_req_addr <= ~a;
   endtask : request
endmodule : fpd_master_model
`default_nettype wire

// ### test/fpd_process_map_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fpd_process_map_tb;
   localparam int H = 4;
   localparam logic [1:0] ok = fpd_pkg::RESP_OKAY;
   localparam logic [1:0] er = fpd_pkg::RESP_SLVERR;
   logic clk, nrst, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0] awaddr, araddr, din, raddr, node;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic awready, wready, bvalid, arready, rvalid, pvalid, rdone, go;
   logic ustb, rstb;
   logic [1:0] bresp, rresp;
   logic [15:0] p3, p4, pdo3, uref, ramp, ureg3, ureg4;
   fpd_pkg::fpd_drive_status_s status;
   fpd_pkg::fpd_prog_write_s prog;
   wire logic [3:0] rdy = {rvalid, arready, bvalid, awready};
   logic [15:0] exp3 [8] = '{16'h0064, 16'h0190, 16'h00A5, 16'h03E8,
      16'h0032, 16'h1111, 16'h2222, 16'h1234};
   logic [15:0] bad [5] = '{16'h0008, 16'h0002, 16'h0003, 16'h0011,
      16'h00F8};
   int mismatches = 0;
   int comparisons = 0;
   fpd_process_map #(.HALF_CHAR_CYCLES(H)) DUT (
      .I_CLK_SYS(clk), .I_NRST(nrst),
      .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
      .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
      .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
      .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
      .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
      .O_RVALID(rvalid), .I_RREADY(rready), .I_STATUS(status),
      .I_DIN(din), .I_PROG(prog), .I_PDI_VALID(pvalid),
      .I_PDI3(p3), .I_PDI4(p4), .O_PDO3(pdo3), .O_USER_REF(uref),
      .O_USER_REF_STB(ustb), .O_RAMP_TIME(ramp), .O_RAMP_TIME_STB(rstb),
      .O_USER_REG3(ureg3), .O_USER_REG4(ureg4), .I_REQ_DONE(rdone),
      .I_REQ_ADDR(raddr), .O_REPLY_GO(go), .O_NODE_ADDR(node));
   fpd_master_model pm (.i_clk(clk), .o_pdi_valid(pvalid), .o_pdi3(p3),
      .o_pdi4(p4), .o_req_done(rdone), .o_req_addr(raddr));
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic till(input int k);
      int n;
      n = 0;
      while (rdy[k] !== 1'b1 && n < 99)
      begin
         @(negedge clk);
         n++;
      end
      if (n == 99)
         chk(0, 1);
   endtask : till
   task automatic wr(input logic [7:0] a, input logic [15:0] d,
      input logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      till(0);
      @(posedge clk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      till(1);
      chk(bresp, r);
      @(posedge clk);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] e,
      input logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      till(2);
      chk(rdata, {16'h0000, e});
      chk(rresp, r);
      @(posedge clk);
      arvalid <= 1'b0;
      rready <= 1'b0;
   endtask : rd
   task automatic pdi(input logic [15:0] w3, input logic [15:0] w4,
      input logic [1:0] s);
      pm.send(w3, w4);
      // strobes stand only in the cycle after the word is taken
      @(negedge clk);
      chk({ustb, rstb}, s);
      repeat (2) @(posedge clk);
   endtask : pdi
   task automatic reply(input logic [7:0] a, input int e);
      int n;
      n = 0;
      pm.request(a);
      while (go !== 1'b1 && n < 300)
      begin
         @(posedge clk);
         n++;
         #1;
      end
      chk(32'(n % 300), 32'(e));
   endtask : reply
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      end_sim();
   end
   initial
   begin
      nrst = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h00000000;
      wstrb = 4'h3;
      din = 8'hA5;
      prog = '0;
      status = {16'h0064, 16'h0190, 16'h03E8, 16'h0032, 16'h1234};
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 5; i++)
         rd(8'(4 * i), 16'h0000, ok);
      rd(fpd_pkg::ADDR_EFF_NODE, 16'h0001, ok);
      rd(8'h30, 16'h0000, er);
      wr(8'h30, 16'h0001, er);
      wr(fpd_pkg::ADDR_USER1, 16'h1111, ok);
      @(posedge clk);
      prog <= {1'b1, 1'b1, 16'h2222};
      @(posedge clk);
      prog <= '0;
      for (int i = 0; i < 8; i++)
      begin
         wr(fpd_pkg::ADDR_OUT3_SRC, 16'(i), ok);
         repeat (5) @(posedge clk);
         chk(pdo3, exp3[i]);
      end
      for (int i = 0; i < 5; i++)
      begin
         wr(8'(4 * i), bad[i], ok);
         rd(8'(4 * i), (i == 0) ? 16'h0007 : 16'h0000, ok);
      end
      pdi(16'h0155, 16'h0BB8, 2'b01);
      chk(uref, 16'h0000);
      chk(ureg3, 16'h0000);
      chk(ramp, 16'h0BB8);
      wr(fpd_pkg::ADDR_IN3_FUNC, 16'h0001, ok);
      wr(fpd_pkg::ADDR_IN4_FUNC, 16'h0001, ok);
      pdi(16'h03E8, 16'h4444, 2'b10);
      chk(uref, 16'h03E8);
      chk(ureg4, 16'h4444);
      chk(ramp, 16'h0BB8);
      wr(fpd_pkg::ADDR_IN3_FUNC, 16'h0002, ok);
      pdi(16'h7777, 16'h0001, 2'b00);
      chk(ureg3, 16'h7777);
      chk(ureg4, 16'h0001);
      wstrb <= 4'h2;
      wr(fpd_pkg::ADDR_USER4, 16'hBBCC, ok);
      wstrb <= 4'h3;
      chk(ureg4, 16'hBB01);
      chk(uref, 16'h03E8);
      wr(fpd_pkg::ADDR_EXT_NODE, 16'h00F7, ok);
      rd(fpd_pkg::ADDR_EFF_NODE, 16'h00F7, ok);
      chk(node, 8'hF7);
      wr(fpd_pkg::ADDR_EXT_NODE, 16'h0000, ok);
      wr(fpd_pkg::ADDR_BASIC_NODE, 16'h003F, ok);
      wr(fpd_pkg::ADDR_BASIC_NODE, 16'h0040, ok);
      rd(fpd_pkg::ADDR_EFF_NODE, 16'h003F, ok);
      chk(node, 8'h3F);
      // wait is (7 + 2 * extra) half characters plus the registering cycle
      reply(8'h3F, 7 * H + 1);
      reply(8'h05, 0);
      wr(fpd_pkg::ADDR_REPLY_DLY, 16'h0010, ok);
      reply(8'h3F, 39 * H + 1);
      end_sim();
   end
endmodule : fpd_process_map_tb
`default_nettype wire
